// ==== logic/dmr_core.sv ====
`timescale 1ns/10ps
module dmr_core (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // access request from the execution logic
  input  wire dmr_pkg::dmr_req_t req_i,
  input  wire dmr_pkg::dmr_stk_t stk_op_i,
  input  wire logic [7:0]       stk_data_i,
  // special-function read data from peripherals
  input  wire logic [7:0]       sfr_rdata_i,
  // answer and special-function routing
  output dmr_pkg::dmr_rsp_t     rsp_o,
  output logic [7:0]            stack_top_pointer_o,
  output logic [1:0]            bank_o,
  // debug report
  output logic                  rec_ovf_o,
  output logic                  rec_unf_o
);
  import dmr_pkg::*;

  typedef struct packed {
    logic [7:0]           sp;
    logic [7:0]           program_status_word;
    logic [DMR_REC_W-1:0] rec;
    logic [5:0]           depth;
    logic                 ovf;
    logic                 unf;
    dmr_rsp_t             rsp;
  } dmr_state_t;

  dmr_state_t st_r;
  dmr_state_t st_nxt;
  logic [7:0] mem_r [256];

  // RAM write port, kept outside the state struct since it is an array
  logic       mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;

  function automatic logic [7:0] reg_addr(input logic [1:0] bank, input logic [2:0] r);
    reg_addr = {3'h0, bank, r};
  endfunction

  function automatic logic bit_sfr(input logic [7:0] baddr);
    bit_sfr = (baddr >= DMR_SFR_BASE); // upper half goes to special-function space
  endfunction

  logic [1:0] bank;
  assign bank = st_r.program_status_word[DMR_BANK_LSB+1:DMR_BANK_LSB];

  always_comb begin
    logic [7:0] ea;
    logic [7:0] ptr;
    logic [7:0] cur;
    logic [7:0] bbyte;
    logic       sfr;
    ea     = 8'h00;
    ptr    = 8'h00;
    cur    = 8'h00;
    bbyte  = 8'h00;
    sfr    = 1'b0;
    st_nxt = st_r;
    mem_we = 1'b0;
    mem_wa = 8'h00;
    mem_wd = 8'h00;
    st_nxt.rsp = '0;
    st_nxt.ovf = 1'b0;
    st_nxt.unf = 1'b0;
    st_nxt.rsp.valid = (req_i.mode != DMR_OP_NONE);
    unique case (req_i.mode)
      DMR_OP_REG: ea = reg_addr(bank, req_i.reg_sel);
      DMR_OP_DIRECT: begin
        ea  = req_i.addr;
        sfr = bit_sfr(req_i.addr);
      end
      DMR_OP_INDIRECT: begin
        // pointer from index register, always RAM
        ptr = mem_r[reg_addr(bank, {2'b00, req_i.idx_sel})];
        ea  = ptr;
      end
      DMR_OP_BIT: begin
        // bit access selected by operand type
        if (bit_sfr(req_i.addr)) begin
          ea  = {req_i.addr[7:3], 3'h0};
          sfr = 1'b1;
        end else begin
          ea = 8'(DMR_BITAREA + {4'h0, req_i.addr[6:3]});
        end
      end
      default: ea = 8'h00;
    endcase
    // psw and sp live here; every other special-function address goes out
    if (sfr && ea == DMR_SP_ADDR) begin
      cur = st_r.sp;
    end else if (sfr && ea == DMR_PSW_ADDR) begin
      cur = st_r.program_status_word;
    end else if (sfr) begin
      cur = sfr_rdata_i; // unoccupied addresses return whatever comes back
    end else begin
      cur = mem_r[ea];
    end
    bbyte = cur;
    bbyte[req_i.addr[2:0]] = req_i.bit_val;
    if (req_i.mode == DMR_OP_BIT) begin
      st_nxt.rsp.rdata = {7'h00, cur[req_i.addr[2:0]]};
    end else begin
      st_nxt.rsp.rdata = cur;
    end
    if (sfr && !(ea == DMR_SP_ADDR || ea == DMR_PSW_ADDR)) begin
      st_nxt.rsp.sfr_sel    = 1'b1;
      st_nxt.rsp.sfr_wr     = req_i.wr;
      st_nxt.rsp.sfr_addr   = ea;
      st_nxt.rsp.sfr_bit    = (req_i.mode == DMR_OP_BIT);
      st_nxt.rsp.sfr_bitpos = req_i.addr[2:0];
      st_nxt.rsp.sfr_wdata  = (req_i.mode == DMR_OP_BIT) ? bbyte : req_i.wdata;
    end
    if (req_i.wr && req_i.mode != DMR_OP_NONE) begin
      if (sfr && ea == DMR_SP_ADDR) begin
        st_nxt.sp = (req_i.mode == DMR_OP_BIT) ? bbyte : req_i.wdata;
      end else if (sfr && ea == DMR_PSW_ADDR) begin
        st_nxt.program_status_word = (req_i.mode == DMR_OP_BIT) ? bbyte : req_i.wdata;
      end else if (!sfr) begin
        mem_we = 1'b1;
        mem_wa = ea;
        mem_wd = (req_i.mode == DMR_OP_BIT) ? bbyte : req_i.wdata;
      end
    end
    // stack ops; they take priority over a plain write to the pointer
    unique case (stk_op_i)
      DMR_STK_PUSH, DMR_STK_INC: begin
        if (stk_op_i == DMR_STK_PUSH) begin
          mem_we = 1'b1;
          mem_wa = 8'(st_r.sp + 8'h01);
          mem_wd = stk_data_i;
        end
        st_nxt.sp = 8'(st_r.sp + 8'h01);
        st_nxt.rec = {st_r.rec[DMR_REC_W-2:0], 1'b1};
        if (st_r.depth == DMR_REC_MAX) st_nxt.ovf = 1'b1;
        else st_nxt.depth = 6'(st_r.depth + 6'h01);
      end
      DMR_STK_CALL: begin
        st_nxt.sp  = 8'(st_r.sp + 8'h02);
        st_nxt.rec = {st_r.rec[DMR_REC_W-3:0], 2'b11};
        if (st_r.depth > 6'(DMR_REC_MAX - 6'h02)) st_nxt.ovf = 1'b1;
        else st_nxt.depth = 6'(st_r.depth + 6'h02);
      end
      DMR_STK_POP, DMR_STK_DEC: begin
        st_nxt.sp  = 8'(st_r.sp - 8'h01);
        st_nxt.rec = {1'b0, st_r.rec[DMR_REC_W-1:1]};
        if (st_r.depth == 6'h00) st_nxt.unf = 1'b1;
        else st_nxt.depth = 6'(st_r.depth - 6'h01);
      end
      DMR_STK_RET: begin
        st_nxt.sp  = 8'(st_r.sp - 8'h02);
        st_nxt.rec = {2'b00, st_r.rec[DMR_REC_W-1:2]};
        if (st_r.depth < 6'h02) st_nxt.unf = 1'b1;
        else st_nxt.depth = 6'(st_r.depth - 6'h02);
      end
      default: ;
    endcase
    if (stk_op_i == DMR_STK_POP) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.rdata = mem_r[st_r.sp];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r    <= '0;
      st_r.sp <= DMR_SP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // RAM has no reset; contents are undefined at power-up as in the core
  always_ff @(posedge clk_i) begin
    if (mem_we) mem_r[mem_wa] <= mem_wd;
  end

  assign rsp_o               = st_r.rsp;
  assign stack_top_pointer_o = st_r.sp;
  assign bank_o              = bank;
  assign rec_ovf_o           = st_r.ovf;
  assign rec_unf_o           = st_r.unf;

  // stack operations as the execution logic presents them at the taking edge
  sequence s_push;
    stk_op_i == DMR_STK_PUSH;
  endsequence

  sequence s_push_full;
    stk_op_i == DMR_STK_PUSH && st_r.depth == DMR_REC_MAX;
  endsequence

  sequence s_call_full;
    stk_op_i == DMR_STK_CALL && st_r.depth > 6'(DMR_REC_MAX - 6'h02);
  endsequence

  sequence s_pop_one;
    stk_op_i == DMR_STK_POP || stk_op_i == DMR_STK_DEC;
  endsequence

  sequence s_ret_short;
    stk_op_i == DMR_STK_RET && st_r.depth < 6'h02;
  endsequence

  // a push followed at once by a pop must hand back the pushed byte
  sequence s_push_then_pop;
    s_push ##1 (stk_op_i == DMR_STK_POP);
  endsequence

  // plain writes to the two registers held here, the pointer write with no stack op competing
  sequence s_pointer_write;
    req_i.mode == DMR_OP_DIRECT && req_i.wr && req_i.addr == DMR_SP_ADDR
      && stk_op_i == DMR_STK_NONE;
  endsequence

  sequence s_status_write;
    req_i.mode == DMR_OP_DIRECT && req_i.wr && req_i.addr == DMR_PSW_ADDR;
  endsequence

  a_push_sp_inc: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_push |=> stack_top_pointer_o == 8'($past(stack_top_pointer_o) + 8'h01))
    else $error("push did not advance the stack pointer");
  a_call_sp_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    stk_op_i == DMR_STK_CALL |=> stack_top_pointer_o == 8'($past(stack_top_pointer_o) + 8'h02))
    else $error("call did not advance the stack pointer by two");
  a_ret_sp_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    stk_op_i == DMR_STK_RET |=> stack_top_pointer_o == 8'($past(stack_top_pointer_o) - 8'h02))
    else $error("return did not lower the stack pointer by two");
  a_direct_sfr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    req_i.mode == DMR_OP_DIRECT && req_i.addr[7] && req_i.addr != DMR_SP_ADDR
      && req_i.addr != DMR_PSW_ADDR |=> rsp_o.sfr_sel)
    else $error("direct upper access not sent to special-function space");
  a_indirect_ram: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    req_i.mode == DMR_OP_INDIRECT |=> !rsp_o.sfr_sel)
    else $error("indirect access reached special-function space");
  a_bit_sfr_align: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rsp_o.sfr_sel && rsp_o.sfr_bit |-> rsp_o.sfr_addr[2:0] == 3'h0)
    else $error("bit access to a byte-only special-function register");
  a_ovf_report: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_push_full |=> rec_ovf_o)
    else $error("record overflow not reported");
  a_unf_report: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    stk_op_i == DMR_STK_POP && st_r.depth == 6'h00 |=> rec_unf_o)
    else $error("record underflow not reported");
  a_rec_shift: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    stk_op_i == DMR_STK_INC |=> st_r.rec[0] && st_r.rec[31:1] == $past(st_r.rec[30:0]))
    else $error("record did not shift in one bit");

  // pointer movement; the 8-bit casts make the wrap at 0x00 and 0xff explicit
  a_pop_lowers: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_pop_one |=> stack_top_pointer_o == 8'($past(stack_top_pointer_o) - 8'h01))
    else $error("pop did not lower the stack pointer");
  a_inc_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    stk_op_i == DMR_STK_INC |=> stack_top_pointer_o == 8'($past(stack_top_pointer_o) + 8'h01))
    else $error("increment did not wrap modulo 256");
  a_pointer_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_pointer_write |=> stack_top_pointer_o == $past(req_i.wdata))
    else $error("write to the stack pointer address was lost");
  a_pointer_reset: assert property (@(posedge clk_i)
    $fell(sys_rst_i) |-> stack_top_pointer_o == DMR_SP_RESET && bank_o == 2'h0)
    else $error("reset did not load the stack pointer");

  // stack record, its debug report and the popped data
  a_call_rec_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    stk_op_i == DMR_STK_CALL |=> st_r.rec[1:0] == 2'b11
      && st_r.rec[DMR_REC_W-1:2] == $past(st_r.rec[DMR_REC_W-3:0]))
    else $error("call did not shift in two record bits");
  a_pop_rec_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_pop_one |=> !st_r.rec[DMR_REC_W-1]
      && st_r.rec[DMR_REC_W-2:0] == $past(st_r.rec[DMR_REC_W-1:1]))
    else $error("pop did not shift out one record bit");
  a_ret_rec_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    stk_op_i == DMR_STK_RET |=> st_r.rec[DMR_REC_W-1:DMR_REC_W-2] == 2'b00
      && st_r.rec[DMR_REC_W-3:0] == $past(st_r.rec[DMR_REC_W-1:2]))
    else $error("return did not shift out two record bits");
  a_call_ovf: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_call_full |=> rec_ovf_o)
    else $error("record overflow on call not reported");
  a_ret_unf: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_ret_short |=> rec_unf_o)
    else $error("record underflow on return not reported");
  a_quiet_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    stk_op_i == DMR_STK_NONE |=> !rec_ovf_o && !rec_unf_o)
    else $error("record flag raised with no stack operation");
  a_push_pop_data: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_push_then_pop |=> rsp_o.rdata == $past(stk_data_i, 2))
    else $error("pop did not return the byte just pushed");

  // address routing and operand type
  a_status_bank: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_status_write |=> bank_o == $past(req_i.wdata[DMR_BANK_LSB+1:DMR_BANK_LSB]))
    else $error("bank select did not follow the status word");
  a_reg_ram: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    req_i.mode == DMR_OP_REG |=> !rsp_o.sfr_sel)
    else $error("working register access left the register banks");
  a_bit_ram_side: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    req_i.mode == DMR_OP_BIT && !req_i.addr[7] |=> !rsp_o.sfr_sel)
    else $error("low bit address did not stay in the bit area");
  a_bit_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    req_i.mode == DMR_OP_BIT && req_i.addr[7] && {req_i.addr[7:3], 3'h0} != DMR_PSW_ADDR
      |=> rsp_o.sfr_bit)
    else $error("bit operand not marked as a bit access");
  a_byte_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    req_i.mode == DMR_OP_DIRECT |=> !rsp_o.sfr_bit)
    else $error("byte operand marked as a bit access");
endmodule

// ==== logic/dmr_pkg.sv ====
// Contract
// - bytes 0x00-0x1f form four banks of eight working registers
// - one bank active, chosen by status word bits 3 and 4
// - indirect accesses take their address from working register 0 or 1
// - bytes 0x20-0x2f are reachable as 128 single bits and as bytes
// - bit address is eight times byte offset from 0x20 plus bit position
// - bit or byte access follows the operand type, not the address
// - push writes stack pointer plus one, then increments the pointer at 0x81
// - reset loads stack pointer with 0x07, so first push lands at 0x08
// - stack may sit anywhere in the 256-byte memory, up to 256 deep
// - 32-bit stack record shifts in one bit per push or increment
// - each subroutine call shifts two bits into the stack record
// - pop or decrement shifts one bit out, return shifts two out
// - record overflow and underflow are reported to debug at full speed
// - direct accesses to 0x80-0xff go to special-function space
// - special-function addresses ending in 0 or 8 are bit-addressable too
// - indirect accesses above 0x7f go to the upper RAM
package dmr_pkg;
  localparam logic [7:0] DMR_SP_ADDR    = 8'h81;
  localparam logic [7:0] DMR_PSW_ADDR   = 8'hd0;
  localparam logic [7:0] DMR_SP_RESET   = 8'h07;
  localparam logic [7:0] DMR_BITAREA    = 8'h20;
  localparam logic [7:0] DMR_SFR_BASE   = 8'h80;
  localparam int         DMR_BANK_LSB   = 3;
  localparam int         DMR_REC_W      = 32;
  localparam logic [5:0] DMR_REC_MAX    = 6'h20;

  typedef enum logic [2:0] {
    DMR_OP_NONE, DMR_OP_DIRECT, DMR_OP_INDIRECT, DMR_OP_REG, DMR_OP_BIT
  } dmr_mode_t;

  typedef enum logic [2:0] {
    DMR_STK_NONE, DMR_STK_PUSH, DMR_STK_POP, DMR_STK_CALL, DMR_STK_RET,
    DMR_STK_INC, DMR_STK_DEC
  } dmr_stk_t;

  typedef struct packed {
    dmr_mode_t  mode;
    logic       wr;
    logic [7:0] addr;
    logic [2:0] reg_sel;
    logic       idx_sel;
    logic       bit_val;
    logic [7:0] wdata;
  } dmr_req_t;

  typedef struct packed {
    logic       valid;
    logic       sfr_sel;
    logic       sfr_wr;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_bit;
    logic [2:0] sfr_bitpos;
    logic [7:0] rdata;
  } dmr_rsp_t;
endpackage

// ==== test/dmr_core_tb_top.sv ====
`timescale 1ns/10ps
module dmr_core_tb_top;
  import dmr_pkg::*;
  typedef struct packed {
    logic       cr;
    logic       ov;
    logic       un;
    logic       s;
    logic [7:0] a;
    logic [7:0] d;
    logic [3:0] bp;
  } dmr_exp_t;
  localparam dmr_exp_t NO_CHK = '0;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  dmr_req_t    req_i;
  dmr_stk_t    stk_op_i;
  logic [7:0]  stk_data_i;
  logic [7:0]  sfr_rdata_i;
  dmr_rsp_t    rsp_o;
  logic [7:0]  sp_o;
  logic [1:0]  bank_o;
  logic        ovf_o;
  logic        unf_o;
  int          n_errors  = 0;
  int          n_tests   = 0;
  logic [31:0] seed      = 32'h3463;
  logic [7:0]  d;
  dmr_exp_t    e;
  dmr_exp_t    expq[$];

  always #5 clk_i = ~clk_i;

  dmr_core DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .stk_op_i(stk_op_i),
    .stk_data_i(stk_data_i), .sfr_rdata_i(sfr_rdata_i), .rsp_o(rsp_o),
    .stack_top_pointer_o(sp_o), .bank_o(bank_o), .rec_ovf_o(ovf_o), .rec_unf_o(unf_o));
  dmr_sfr_model PM (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .sfr_rdata_o(sfr_rdata_i));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function automatic dmr_exp_t ex(input logic cr, ov, un, s, input logic [7:0] a, dv,
                                  input logic [3:0] bp = 4'h0);
    return '{cr, ov, un, s, a, dv, bp};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    n_tests++;
    if (seen !== expv) begin
      n_errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic op(input dmr_mode_t m, input logic w, input logic [7:0] a,
                    input logic [2:0] r, input logic [7:0] wd, input dmr_stk_t so,
                    input dmr_exp_t xv);
    @(negedge clk_i);
    req_i = '{mode: m, wr: w, addr: a, reg_sel: r, idx_sel: r[0], bit_val: wd[0], wdata: wd};
    stk_op_i = so;
    stk_data_i = wd;
    // only requests, pops and expected flag pulses produce an answer
    if (m != DMR_OP_NONE || so == DMR_STK_POP || xv.ov || xv.un) expq.push_back(xv);
  endtask

  task automatic idle();
    @(negedge clk_i);
    req_i.mode = DMR_OP_NONE;
    stk_op_i = DMR_STK_NONE;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one note is consumed per answer; an answer with no note is a mismatch
  always @(posedge clk_i) begin
    #1;
    if (rsp_o.valid === 1'b1 || ovf_o === 1'b1 || unf_o === 1'b1) begin
      if (expq.size() == 0) begin
        chk(8'h01, 8'h00);
      end else begin
        e = expq.pop_front();
        chk({6'h0, ovf_o, unf_o}, {6'h0, e.ov, e.un});
        chk({7'h0, rsp_o.sfr_sel}, {7'h0, e.s});
        if (e.s) chk(rsp_o.sfr_addr, e.a);
        if (e.s) chk({7'h0, rsp_o.sfr_wr}, {7'h0, !e.cr});
        if (e.s && !e.cr) chk(rsp_o.sfr_wdata, e.d);
        if (e.s) chk({4'h0, rsp_o.sfr_bit, rsp_o.sfr_bitpos}, {4'h0, e.bp});
        if (e.cr) chk(rsp_o.rdata, e.d);
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    chk(8'h01, 8'h00);
    report_and_stop();
  end

  initial begin
    req_i = '0;
    stk_op_i = DMR_STK_NONE;
    stk_data_i = 8'h00;
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk(sp_o, 8'h07);
    chk({6'h0, bank_o}, 8'h00);
    d = rnd();
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, d, DMR_STK_PUSH, NO_CHK);
    op(DMR_OP_DIRECT, 1'b0, 8'h08, 3'h0, 8'h00, DMR_STK_NONE, ex(1, 0, 0, 0, 0, d));
    op(DMR_OP_DIRECT, 1'b1, DMR_PSW_ADDR, 3'h0, 8'h10, DMR_STK_NONE, NO_CHK);
    idle();
    chk(sp_o, 8'h08);
    chk({6'h0, bank_o}, 8'h02);
    d = rnd();
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, d, DMR_STK_PUSH, NO_CHK);
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, 8'h00, DMR_STK_POP, ex(1, 0, 0, 0, 0, d));
    d = rnd();
    op(DMR_OP_REG, 1'b1, 8'h00, 3'h1, d, DMR_STK_NONE, NO_CHK);
    op(DMR_OP_DIRECT, 1'b0, 8'h11, 3'h0, 8'h00, DMR_STK_NONE, ex(1, 0, 0, 0, 0, d));
    op(DMR_OP_REG, 1'b1, 8'h00, 3'h0, 8'h90, DMR_STK_NONE, NO_CHK);
    d = rnd();
    op(DMR_OP_INDIRECT, 1'b1, 8'h00, 3'h0, d, DMR_STK_NONE, NO_CHK);
    op(DMR_OP_INDIRECT, 1'b0, 8'h00, 3'h0, 8'h00, DMR_STK_NONE, ex(1, 0, 0, 0, 0, d));
    op(DMR_OP_DIRECT, 1'b0, 8'h90, 3'h0, 8'h00, DMR_STK_NONE, ex(1, 0, 0, 1, 8'h90, 8'h09));
    op(DMR_OP_BIT, 1'b0, 8'h93, 3'h0, 8'h00, DMR_STK_NONE,
       ex(1, 0, 0, 1, 8'h90, 8'h01, 4'hb));
    d = rnd();
    op(DMR_OP_DIRECT, 1'b1, 8'h98, 3'h0, d, DMR_STK_NONE, ex(0, 0, 0, 1, 8'h98, d));
    op(DMR_OP_BIT, 1'b1, 8'h9a, 3'h0, 8'h01, DMR_STK_NONE,
       ex(0, 0, 0, 1, 8'h98, 8'h8d, 4'ha));
    op(DMR_OP_DIRECT, 1'b1, 8'h22, 3'h0, 8'h00, DMR_STK_NONE, NO_CHK);
    op(DMR_OP_DIRECT, 1'b1, 8'h2f, 3'h0, 8'h00, DMR_STK_NONE, NO_CHK);
    op(DMR_OP_BIT, 1'b1, 8'h13, 3'h0, 8'h01, DMR_STK_NONE, NO_CHK);
    op(DMR_OP_BIT, 1'b1, 8'h7f, 3'h0, 8'h01, DMR_STK_NONE, NO_CHK);
    op(DMR_OP_DIRECT, 1'b0, 8'h22, 3'h0, 8'h00, DMR_STK_NONE, ex(1, 0, 0, 0, 0, 8'h08));
    op(DMR_OP_DIRECT, 1'b0, 8'h2f, 3'h0, 8'h00, DMR_STK_NONE, ex(1, 0, 0, 0, 0, 8'h80));
    op(DMR_OP_DIRECT, 1'b1, DMR_SP_ADDR, 3'h0, 8'hff, DMR_STK_NONE, NO_CHK);
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, 8'h00, DMR_STK_INC, NO_CHK);
    idle();
    chk(sp_o, 8'h00);
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, 8'h00, DMR_STK_DEC, NO_CHK);
    idle();
    chk(sp_o, 8'hff);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk(sp_o, 8'h07);
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, 8'h00, DMR_STK_POP, ex(0, 0, 1, 0, 0, 0));
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, 8'h00, DMR_STK_RET, ex(0, 0, 1, 0, 0, 0));
    for (int i = 0; i < 16; i++) begin
      op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, 8'h00, DMR_STK_CALL, NO_CHK);
    end
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, rnd(), DMR_STK_PUSH, ex(0, 1, 0, 0, 0, 0));
    op(DMR_OP_NONE, 1'b0, 8'h00, 3'h0, 8'h00, DMR_STK_CALL, ex(0, 1, 0, 0, 0, 0));
    idle();
    for (int i = 0; i < 20 && expq.size() != 0; i++) @(negedge clk_i);
    if (expq.size() != 0) chk(8'h01, 8'h00);
    report_and_stop();
  end
endmodule

// ==== test/dmr_sfr_model.sv ====
`timescale 1ns/10ps
module dmr_sfr_model import dmr_pkg::*; (
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     sys_rst_i,
  // request seen by the peripherals
  input  wire dmr_req_t req_i,
  // read data back to the block
  output logic [7:0]    sfr_rdata_o
);
  logic [7:0] noise_r;
  logic [7:0] byte_addr;
  // unselected: a pattern that moves every cycle, so no stale value can pass for data
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) noise_r <= 8'h5a;
    else noise_r <= {noise_r[6:0], ~noise_r[7]};
  end
  always_comb begin
    byte_addr = (req_i.mode == DMR_OP_BIT) ? {req_i.addr[7:3], 3'h0} : req_i.addr;
    // every special address of a direct or bit access is driven here, occupied or not
    if ((req_i.mode == DMR_OP_DIRECT || req_i.mode == DMR_OP_BIT) && byte_addr[7]) begin
      sfr_rdata_o = {byte_addr[3:0], byte_addr[7:4]};
    end else begin
      sfr_rdata_o = noise_r;
    end
  end
endmodule
